// ### bench/access_gen.sv
// Far-side model: memories that finish accesses and blocks.
// Assumes calls start just after a rising edge of ref_clk.
`timescale 1ns/1ns
module access_gen (
	input wire logic ref_clk,
	output logic access_done,
	output logic block_done
);
	initial begin
		access_done = 1'b0;
		block_done = 1'b0;
	end
	// A prompt side holds the pulse line high across back-to-back accesses.
	task automatic run(input int n, input bit slow, input bit blk);
		for (int i = 0; i < n; i++) begin
			access_done <= 1'b1;
			@(posedge ref_clk);
			if (slow || i == n - 1) begin
				access_done <= 1'b0;
				if (slow) repeat (1 + $urandom_range(2)) @(posedge ref_clk);
			end
		end
		if (blk) begin
			block_done <= 1'b1;
			@(posedge ref_clk);
			block_done <= 1'b0;
		end
	endtask
endmodule

// ### bench/dma_address_update_control_tb.sv
// Self-checking bench for the DMA address-update control.
// Assumes the far-side model access_gen and the shared package.
`timescale 1ns/1ns
module dma_address_update_control_tb;
	logic ref_clk, rst_n, reg_wr, reg_rd, access_done, block_done;
	logic transfer_enable, irq;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, src_addr, dst_addr, s, d, o, e, f;
	int err_total = 0;
	int cmp_count = 0;
	logic [31:0] oc[4] = '{32'h0220_8100, 32'h0220_0100, 32'h0220_8000,
		32'h0220_8100};
	dma_addr_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .access_done(access_done),
		.block_done(block_done), .src_addr(src_addr), .dst_addr(dst_addr),
		.transfer_enable(transfer_enable), .irq(irq));
	access_gen far (.ref_clk(ref_clk), .access_done(access_done),
		.block_done(block_done));
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("errors %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// A gap cycle after each strobe keeps a strobe from being set twice.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		v = reg_rdata;
		@(posedge ref_clk);
	endtask
	task automatic look(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask
	function automatic logic [31:0] nxt(input logic [31:0] a, input int c,
		input int sz, input logic [31:0] off);
		case (c)
			1: return a + off;
			2: return a + (32'h1 << sz);
			3: return a - (32'h1 << sz);
			default: return a;
		endcase
	endfunction
	task automatic arm(input logic [31:0] c, input logic [31:0] m);
		s = $urandom & 32'hffff_fff0;
		d = $urandom;
		o = $urandom;
		wr(dma_ctrl_pkg::src_addr_offs, s);
		wr(dma_ctrl_pkg::dst_addr_offs, d);
		wr(dma_ctrl_pkg::step_offs, o);
		wr(dma_ctrl_pkg::ctrl_offs, c);
		wr(dma_ctrl_pkg::mode_offs, m);
	endtask
	initial begin
		repeat (5000) @(posedge ref_clk);
		err_total++;
		complete_run;
	end
	initial begin
		logic [31:0] v;
		bit stop;
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		void'($urandom(50));
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rd(dma_ctrl_pkg::ctrl_offs, v);
		check(v, 32'h0000_0000);
		wr(dma_ctrl_pkg::ctrl_offs, 32'hffff_ffff);
		rd(dma_ctrl_pkg::ctrl_offs, v);
		check(v, 32'h0333_9f00);
		rd(8'h1c, v);
		check(v, 32'h0000_0000);
		wr(dma_ctrl_pkg::mask_offs, 32'h1);
		for (int c = 0; c < 4; c++) begin
			for (int sz = 0; sz < 3; sz++) begin
				arm(32'h0200_0000 | (c << 20) | ((3 - c) << 16), 1 | (sz << 4));
				far.run(3, 1'($urandom_range(1)), 1'b0);
				e = s;
				f = d;
				repeat (3) begin
					e = nxt(e, c, sz, o);
					f = nxt(f, 3 - c, sz, o);
				end
				look(0);
				check(src_addr, e);
				check(dst_addr, f);
				@(posedge ref_clk);
			end
		end
		for (int dir = 0; dir < 2; dir++) begin
			arm(32'h0222_0000, 32'h5 | (dir << 3));
			far.run(2, 1'b1, 1'b0);
			look(0);
			check(src_addr, dir ? s : s + 32'h2);
			check(dst_addr, dir ? d + 32'h2 : d);
			@(posedge ref_clk);
		end
		for (int a = 0; a < 3; a++) begin
			arm((a << 24) | 32'h0022_0000, 32'h3);
			far.run(2, 1'b0, 1'b1);
			look(0);
			check(src_addr, a == 0 ? s : s + 32'h2);
			check(dst_addr, a == 1 ? d : d + 32'h2);
			@(posedge ref_clk);
			wr(dma_ctrl_pkg::status_offs, 32'h3);
		end
		for (int i = 0; i < 4; i++) begin
			arm(oc[i], i == 3 ? 32'h3 : 32'h1);
			far.run(4, 1'b0, 1'b0);
			stop = (oc[i] & 32'h8100) == 32'h8100 && i != 3;
			look(3);
			e = oc[i][8] ? s : s + 32'h4;
			check(src_addr, e);
			check(32'(transfer_enable), 32'(!stop));
			check(32'(irq), 32'(stop));
			@(posedge ref_clk);
			rd(dma_ctrl_pkg::status_offs, v);
			check(v, 32'(stop));
			if (i == 3) begin
				far.run(0, 1'b0, 1'b1);
				look(3);
				check(32'(transfer_enable), 32'h0);
				check(32'(irq), 32'h1);
				@(posedge ref_clk);
				rd(dma_ctrl_pkg::status_offs, v);
				check(v, 32'h0000_0003);
			end
			wr(dma_ctrl_pkg::status_offs, 32'h3);
			wr(dma_ctrl_pkg::mode_offs, i == 3 ? 32'h3 : 32'h1);
			far.run(1, 1'b0, 1'b0);
			look(0);
			check(src_addr, e + 32'h1);
			check(32'(irq), 32'h0);
			@(posedge ref_clk);
			wr(dma_ctrl_pkg::mode_offs, 32'h0);
		end
		// A reset after the last run, with the channel disabled, must bring the control fields back to zero.
		rst_n <= 1'b0;
		@(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rd(dma_ctrl_pkg::ctrl_offs, v);
		check(v, 32'h0000_0000);
		complete_run;
	end
endmodule

// ### rtl/addr_step.sv
// Next-address calculator for one DMA address counter.
// Assumes the size code is 0, 1 or 2 for byte, word and longword.
`timescale 1ns/1ns
module addr_step (
	addr_step_if.calc s
);
	logic [31:0] delta;
	logic [31:0] raw;
	logic [31:0] mask;

	always_comb begin
		delta = 32'h0000_0001 << s.size;
		mask = dma_ctrl_pkg::area_mask(s.area);
		case (s.mode)
			dma_ctrl_pkg::upd_fixed: raw = s.addr;
			dma_ctrl_pkg::upd_offset: raw = s.addr + s.offset;
			dma_ctrl_pkg::upd_inc: raw = s.addr + delta;
			default: raw = s.addr - delta;
		endcase
		// Upper bits stay put; a carry or borrow leaving the low bits wraps.
		if (mask != 32'h0000_0000) begin
			s.next = (s.addr & ~mask) | (raw & mask);
			s.ovf = ((raw ^ s.addr) & ~mask) != 32'h0000_0000;
		end else begin
			s.next = raw;
			s.ovf = 1'b0;
		end
	end
endmodule

// ### rtl/dma_addr_ctrl.sv
// Per-channel address-update control with register port and interrupt.
// Assumes access_done and block_done are one-cycle pulses on ref_clk.
`timescale 1ns/1ns
module dma_addr_ctrl (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic access_done,
	input wire logic block_done,
	output logic [31:0] src_addr,
	output logic [31:0] dst_addr,
	output logic transfer_enable,
	output logic irq
);
	localparam int ne = dma_ctrl_pkg::evt_count;

	logic [31:0] ctrl_ff, nxt_ctrl;
	logic [5:0] mode_ff, nxt_mode;
	logic [31:0] src_ff, nxt_src;
	logic [31:0] dst_ff, nxt_dst;
	logic [31:0] src_start_ff, nxt_src_start;
	logic [31:0] dst_start_ff, nxt_dst_start;
	logic [31:0] step_ff, nxt_step;
	logic pend_ff, nxt_pend;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [ne-1:0] evt;
	logic [ne-1:0] status_q;
	logic [ne-1:0] mask_q;

	logic [1:0] area_sel, src_mode, dst_mode, size;
	logic [4:0] src_area;
	logic ovf_ie, blk_mode, single, dir, en;
	logic acc, src_live, dst_live, area_on, ovf_hit, blk_end;
	logic wr_ctrl, wr_src, wr_dst, wr_mode;

	addr_step_if s_if ();
	addr_step_if d_if ();

	addr_step u_src_step (
		.s(s_if)
	);

	addr_step u_dst_step (
		.s(d_if)
	);

	irq_status #(
		.n_evt(ne)
	) u_irq (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.evt(evt),
		.status_wr(reg_wr && reg_addr == dma_ctrl_pkg::status_offs),
		.mask_wr(reg_wr && reg_addr == dma_ctrl_pkg::mask_offs),
		.wdata(reg_wdata[ne-1:0]),
		.status_ff(status_q),
		.mask_ff(mask_q),
		.irq_ff(irq)
	);

	always_comb begin
		area_sel = ctrl_ff[dma_ctrl_pkg::area_sel_pos +: 2];
		src_mode = ctrl_ff[dma_ctrl_pkg::src_upd_pos +: 2];
		dst_mode = ctrl_ff[dma_ctrl_pkg::dst_upd_pos +: 2];
		ovf_ie = ctrl_ff[dma_ctrl_pkg::src_ovf_ie_pos];
		src_area = ctrl_ff[dma_ctrl_pkg::src_area_pos +: 5];
		en = mode_ff[dma_ctrl_pkg::mode_en_pos];
		blk_mode = mode_ff[dma_ctrl_pkg::mode_blk_pos];
		single = mode_ff[dma_ctrl_pkg::mode_single_pos];
		dir = mode_ff[dma_ctrl_pkg::mode_dir_pos];
		size = mode_ff[dma_ctrl_pkg::mode_size_pos +: 2];
		wr_ctrl = reg_wr && reg_addr == dma_ctrl_pkg::ctrl_offs;
		wr_src = reg_wr && reg_addr == dma_ctrl_pkg::src_addr_offs;
		wr_dst = reg_wr && reg_addr == dma_ctrl_pkg::dst_addr_offs;
		wr_mode = reg_wr && reg_addr == dma_ctrl_pkg::mode_offs;
		acc = access_done && en;
		blk_end = block_done && en;
		src_live = !(single && dir);
		dst_live = !(single && !dir);
		// Without an extended area the enable bit has nothing to act on.
		area_on = dma_ctrl_pkg::area_mask(src_area) != 32'h0000_0000;
		ovf_hit = acc && src_live && s_if.ovf && ovf_ie && area_on;
	end

	always_comb begin
		s_if.addr = src_ff;
		s_if.offset = step_ff;
		s_if.mode = src_mode;
		s_if.size = size;
		s_if.area = src_area;
		d_if.addr = dst_ff;
		d_if.offset = step_ff;
		d_if.mode = dst_mode;
		d_if.size = size;
		d_if.area = 5'h00;
	end

	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_mode = mode_ff;
		nxt_src = src_ff;
		nxt_dst = dst_ff;
		nxt_src_start = src_start_ff;
		nxt_dst_start = dst_start_ff;
		nxt_step = step_ff;
		nxt_pend = pend_ff;
		evt = '0;
		if (acc && src_live) begin
			nxt_src = s_if.next;
		end
		if (acc && dst_live) begin
			nxt_dst = d_if.next;
		end
		if (ovf_hit) begin
			if (blk_mode) begin
				nxt_pend = 1'b1;
			end else begin
				nxt_mode[dma_ctrl_pkg::mode_en_pos] = 1'b0;
				evt[dma_ctrl_pkg::evt_end_status] = 1'b1;
			end
		end
		if (blk_end && blk_mode) begin
			evt[dma_ctrl_pkg::evt_block] = 1'b1;
			// The area side returns to its start; the other side runs on.
			if (area_sel == dma_ctrl_pkg::area_src) begin
				nxt_src = src_start_ff;
			end else if (area_sel == dma_ctrl_pkg::area_dst) begin
				nxt_dst = dst_start_ff;
			end
			if (pend_ff || ovf_hit) begin
				nxt_mode[dma_ctrl_pkg::mode_en_pos] = 1'b0;
				evt[dma_ctrl_pkg::evt_end_status] = 1'b1;
				nxt_pend = 1'b0;
			end
		end
		// Reserved bits are masked off here and so can never be set.
		if (wr_ctrl) begin
			nxt_ctrl = reg_wdata & dma_ctrl_pkg::ctrl_wmask;
		end
		if (wr_src) begin
			nxt_src = reg_wdata;
			nxt_src_start = reg_wdata;
		end
		if (wr_dst) begin
			nxt_dst = reg_wdata;
			nxt_dst_start = reg_wdata;
		end
		if (reg_wr && reg_addr == dma_ctrl_pkg::step_offs) begin
			nxt_step = reg_wdata;
		end
		// Setting the enable again touches no counter, so work resumes.
		if (wr_mode) begin
			nxt_mode = reg_wdata[5:0];
		end
	end

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (!reg_rd) begin
			nxt_rdata = 32'h0000_0000;
		end else if (reg_addr == dma_ctrl_pkg::ctrl_offs) begin
			nxt_rdata = ctrl_ff & dma_ctrl_pkg::ctrl_wmask;
		end else if (reg_addr == dma_ctrl_pkg::src_addr_offs) begin
			nxt_rdata = src_ff;
		end else if (reg_addr == dma_ctrl_pkg::dst_addr_offs) begin
			nxt_rdata = dst_ff;
		end else if (reg_addr == dma_ctrl_pkg::step_offs) begin
			nxt_rdata = step_ff;
		end else if (reg_addr == dma_ctrl_pkg::mode_offs) begin
			nxt_rdata = {26'h0, mode_ff};
		end else if (reg_addr == dma_ctrl_pkg::status_offs) begin
			nxt_rdata = {30'h0, status_q};
		end else if (reg_addr == dma_ctrl_pkg::mask_offs) begin
			nxt_rdata = {30'h0, mask_q};
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= dma_ctrl_pkg::ctrl_rst;
			mode_ff <= dma_ctrl_pkg::mode_rst;
			src_ff <= 32'h0000_0000;
			dst_ff <= 32'h0000_0000;
			src_start_ff <= 32'h0000_0000;
			dst_start_ff <= 32'h0000_0000;
			step_ff <= 32'h0000_0000;
			pend_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else begin
			ctrl_ff <= nxt_ctrl;
			mode_ff <= nxt_mode;
			src_ff <= nxt_src;
			dst_ff <= nxt_dst;
			src_start_ff <= nxt_src_start;
			dst_start_ff <= nxt_dst_start;
			step_ff <= nxt_step;
			pend_ff <= nxt_pend;
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;
	assign src_addr = src_ff;
	assign dst_addr = dst_ff;
	assign transfer_enable = mode_ff[dma_ctrl_pkg::mode_en_pos];

	chk_reserved_zero: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		reg_rd && reg_addr == dma_ctrl_pkg::ctrl_offs |=>
		reg_rdata[23:22] == 2'h0 && reg_rdata[19:18] == 2'h0 &&
		reg_rdata[14:13] == 2'h0)
		else $error("reserved control bits read non-zero");

	chk_ovf_stop: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		ovf_hit && !blk_mode && !wr_mode |=>
		!transfer_enable ##1 status_q[dma_ctrl_pkg::evt_end_status])
		else $error("overflow did not stop the channel");

	chk_block_defer: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		ovf_hit && blk_mode && !block_done && !wr_mode |=>
		transfer_enable && pend_ff)
		else $error("block overflow stopped before block end");

	chk_no_ie_run: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		acc && !ovf_ie && !block_done && !wr_mode |=>
		transfer_enable)
		else $error("overflow stopped channel with enable off");

	chk_src_fixed: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		acc && src_mode == dma_ctrl_pkg::upd_fixed && !wr_src &&
		!blk_end |=> src_addr == $past(src_addr))
		else $error("fixed source address moved");

	chk_src_offset: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		acc && src_live && src_mode == dma_ctrl_pkg::upd_offset &&
		!area_on && !wr_src && !blk_end |=>
		src_addr == $past(src_addr) + $past(step_ff))
		else $error("source offset step wrong");

	chk_src_incr: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		acc && src_live && src_mode == dma_ctrl_pkg::upd_inc && !area_on &&
		!wr_src && !blk_end |=>
		src_addr == $past(src_addr) + (32'h0000_0001 << $past(size)))
		else $error("source increment by access size wrong");

	chk_src_decr: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		acc && src_live && src_mode == dma_ctrl_pkg::upd_dec && !area_on &&
		!wr_src && !blk_end |=>
		src_addr == $past(src_addr) - (32'h0000_0001 << $past(size)))
		else $error("source decrement by access size wrong");

	chk_dst_fixed: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		acc && dst_mode == dma_ctrl_pkg::upd_fixed && !wr_dst &&
		!blk_end |=> $stable(dst_addr))
		else $error("fixed destination address moved");

	chk_dst_incr: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		acc && dst_live && dst_mode == dma_ctrl_pkg::upd_inc &&
		!wr_dst && !blk_end |=>
		dst_addr == $past(dst_addr) + (32'h0000_0001 << $past(size)))
		else $error("destination increment by access size wrong");

	chk_dst_decr: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		acc && dst_live && dst_mode == dma_ctrl_pkg::upd_dec &&
		!wr_dst && !blk_end |=>
		dst_addr == $past(dst_addr) - (32'h0000_0001 << $past(size)))
		else $error("destination decrement by access size wrong");

	chk_single_ignore: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		acc && single && dir && !wr_src && !blk_end |=>
		$stable(src_addr))
		else $error("unused source counter moved in single mode");

	chk_dst_ignore: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		acc && single && !dir && !wr_dst && !blk_end |=>
		$stable(dst_addr))
		else $error("unused destination counter moved in single mode");

	chk_area_upper: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		acc && area_on && !wr_src && !blk_end |=>
		((src_addr ^ $past(src_addr)) & ~dma_ctrl_pkg::area_mask(src_area))
		== 32'h0000_0000)
		else $error("upper source bits changed inside area");

	chk_src_reload: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		blk_end && blk_mode && area_sel == dma_ctrl_pkg::area_src &&
		!acc && !wr_src |=> src_addr == $past(src_start_ff))
		else $error("source area did not return to its start");

	chk_dst_reload: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		blk_end && blk_mode && area_sel == dma_ctrl_pkg::area_dst &&
		!acc && !wr_dst |=> dst_addr == $past(dst_start_ff))
		else $error("destination area did not return to its start");

	chk_no_reload: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		blk_end && blk_mode && area_sel == dma_ctrl_pkg::area_none &&
		!acc && !wr_src && !wr_dst |=>
		$stable(src_addr) && $stable(dst_addr))
		else $error("counter reloaded with no area selected");

	chk_resume: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		wr_mode && !acc && !blk_end && !wr_src |=>
		$stable(src_addr))
		else $error("re-enable disturbed the source counter");
endmodule

// ### rtl/irq_status.sv
// Sticky event status, mask and level interrupt output.
// Assumes events and writes arrive on the same clock as the registers.
`timescale 1ns/1ns
module irq_status #(
	parameter int n_evt = 2
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [n_evt-1:0] evt,
	input wire logic status_wr,
	input wire logic mask_wr,
	input wire logic [n_evt-1:0] wdata,
	output logic [n_evt-1:0] status_ff,
	output logic [n_evt-1:0] mask_ff,
	output logic irq_ff
);
	logic [n_evt-1:0] nxt_status;
	logic [n_evt-1:0] nxt_mask;
	logic nxt_irq;

	// The status and mask fields must fit one 32-bit register word.
	if (n_evt < 1 || n_evt > 32) begin : g_bad_n_evt
		$error("irq_status: n_evt out of range");
	end

	always_comb begin
		nxt_status = status_ff;
		nxt_mask = mask_ff;
		// A clear never swallows an event arriving in the same cycle.
		if (status_wr) begin
			nxt_status = status_ff & ~wdata;
		end
		nxt_status = nxt_status | evt;
		if (mask_wr) begin
			nxt_mask = wdata;
		end
		nxt_irq = |(nxt_status & nxt_mask);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_ff <= '0;
			mask_ff <= '0;
			irq_ff <= 1'b0;
		end else begin
			status_ff <= nxt_status;
			mask_ff <= nxt_mask;
			irq_ff <= nxt_irq;
		end
	end

	chk_set_wins: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		evt[0] |=> status_ff[0])
		else $error("event lost against a clear");
endmodule

// ### shared/addr_step_if.sv
// Carries one address counter to its update calculator and back.
// Assumes both ends run on the same clock; the calculator is combinational.
`timescale 1ns/1ns
interface addr_step_if;
	logic [31:0] addr;
	logic [31:0] offset;
	logic [1:0] mode;
	logic [1:0] size;
	logic [4:0] area;
	logic [31:0] next;
	logic ovf;
	modport user (output addr, offset, mode, size, area, input next, ovf);
	modport calc (input addr, offset, mode, size, area, output next, ovf);
endinterface

// ### shared/dma_ctrl_pkg.sv
// Constants, register map and field layout of the DMA address-update control.
// Assumes a 32-bit register port with an 8-bit byte address.
package dma_ctrl_pkg;

	localparam logic [7:0] ctrl_offs = 8'h00;
	localparam logic [7:0] src_addr_offs = 8'h04;
	localparam logic [7:0] dst_addr_offs = 8'h08;
	localparam logic [7:0] step_offs = 8'h0c;
	localparam logic [7:0] mode_offs = 8'h10;
	localparam logic [7:0] status_offs = 8'h14;
	localparam logic [7:0] mask_offs = 8'h18;

	localparam int area_sel_pos = 24;
	localparam int src_upd_pos = 20;
	localparam int dst_upd_pos = 16;
	localparam int src_ovf_ie_pos = 15;
	localparam int src_area_pos = 8;

	localparam logic [31:0] ctrl_rst = 32'h0000_0000;
	localparam logic [31:0] ctrl_wmask = 32'h0333_9f00;

	localparam int mode_en_pos = 0;
	localparam int mode_blk_pos = 1;
	localparam int mode_single_pos = 2;
	localparam int mode_dir_pos = 3;
	localparam int mode_size_pos = 4;
	localparam logic [5:0] mode_rst = 6'h00;

	localparam logic [1:0] upd_fixed = 2'h0;
	localparam logic [1:0] upd_offset = 2'h1;
	localparam logic [1:0] upd_inc = 2'h2;
	localparam logic [1:0] upd_dec = 2'h3;

	localparam logic [1:0] area_src = 2'h0;
	localparam logic [1:0] area_dst = 2'h1;
	localparam logic [1:0] area_none = 2'h2;

	localparam logic [4:0] area_code_max = 5'h1a;
	localparam int evt_end_status = 0;
	localparam int evt_block = 1;
	localparam int evt_count = 2;

	// Code n (1..26) keeps the low n+1 address bits moving; 0 means none.
	function automatic logic [31:0] area_mask(input logic [4:0] code);
		logic [31:0] m;
		m = 32'h0000_0000;
		if (code != 5'h00 && code <= area_code_max) begin
			m = (32'h0000_0004 << (code - 5'h01)) - 32'h0000_0001;
		end
		return m;
	endfunction

endpackage
